// file: logic/kefl_event_fifo_lock.sv
// Key event queue with overflow policies and keypad lock state machine.
// Assumes scan events arrive on ev_clk and registers are reached over a simple strobe port.
`timescale 1ns/10ps
module kefl_event_fifo_lock
  import kefl_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEFAULT
)
(
  input  logic                 clk,
  input  logic                 sys_rst,
  input  logic [7:0]           reg_addr,
  input  logic [7:0]           reg_wdata,
  input  logic                 reg_wr,
  input  logic                 reg_rd,
  output logic [7:0]           reg_rdata,
  output logic                 reg_rvalid,
  input  logic                 cfg_overflow_alert_enable,
  input  logic                 cfg_overflow_keep_newest,
  input  logic                 cfg_input_event_mode,
  input  logic [GPI_SEL_W-1:0] input_event_select,
  input  logic [6:0]           first_unlock_key,
  input  logic [6:0]           second_unlock_key,
  input  logic [7:0]           lock_timers,
  output logic                 irq_n,
  input  logic                 ev_clk,
  input  logic                 ev_strobe,
  input  logic                 ev_is_gpi,
  input  logic                 ev_on_col,
  input  logic [2:0]           ev_row,
  input  logic [3:0]           ev_col,
  input  logic                 ev_press,
  output logic                 ev_busy
);

  // Key code of an event source
  function automatic logic [6:0] key_code(input logic gpi, input logic on_col,
                                          input logic [2:0] row, input logic [3:0] col);
    if (!gpi)
      key_code = 7'(row * MATRIX_COLS + col + MATRIX_BASE);
    else if (on_col)
      key_code = 7'(GPI_COL_BASE + col);
    else
      key_code = 7'(GPI_ROW_BASE + row);
  endfunction

  // End of one second on a running prescaler
  function automatic logic sec_done(input logic [PRESCALE_W-1:0] pre);
    sec_done = (pre == PRESCALE_W'(SEC_CYCLES - 1));
  endfunction

  // Link domain: reset sync, capture and request toggle
  logic       lrst_s1_reg, lrst_s2_reg;
  logic       req_tog_reg, ack_s1_reg, ack_s2_reg, busy_reg;
  logic       cap_gpi_reg, cap_col_reg, cap_press_reg;
  logic [2:0] cap_row_reg;
  logic [3:0] cap_colx_reg;
  logic       req_s1_reg, req_s2_reg, req_s3_reg;

  always_ff @(posedge ev_clk)
  begin
    lrst_s1_reg <= sys_rst;
    lrst_s2_reg <= lrst_s1_reg;
    ack_s1_reg  <= req_s3_reg;
    ack_s2_reg  <= ack_s1_reg;
  end

  // Data holds still while busy, so the system side reads it without its own sync
  always_ff @(posedge ev_clk)
  begin
    if (lrst_s2_reg)
    begin
      req_tog_reg <= 1'b0;
      busy_reg    <= 1'b0;
    end
    else if (ev_strobe && !busy_reg)
    begin
      req_tog_reg   <= ~req_tog_reg;
      busy_reg      <= 1'b1;
      cap_gpi_reg   <= ev_is_gpi;
      cap_col_reg   <= ev_on_col;
      cap_row_reg   <= ev_row;
      cap_colx_reg  <= ev_col;
      cap_press_reg <= ev_press;
    end
    else if (busy_reg && (ack_s2_reg == req_tog_reg))
      busy_reg <= 1'b0;
  end

  assign ev_busy = busy_reg;

  // System domain request synchroniser; third stage is the acknowledge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end
    else
    begin
      req_s1_reg <= req_tog_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  // Event decode and queue bookkeeping
  kefl_lock_state_type lock_state_reg, lock_state_next;
  logic [3:0] count_reg, count_next, count_after_pop, push_idx;
  logic [7:0] flags_reg, flags_set, head;
  logic [6:0] ev_code;
  logic [4:0] sel_idx;
  logic       ev_new, sel_ok, locked, record, full, ovf, push, drop_oldest, host_pop;
  logic       lock_wr, lock_press, mask_fire, unlock_done;

  assign ev_new   = req_s2_reg ^ req_s3_reg;
  assign ev_code  = key_code(cap_gpi_reg, cap_col_reg, cap_row_reg, cap_colx_reg);
  assign sel_idx  = cap_col_reg ? 5'(GPI_COL_SEL + cap_colx_reg) : 5'(cap_row_reg);
  assign sel_ok   = !cap_gpi_reg || input_event_select[sel_idx];
  assign locked   = (lock_state_reg != LK_UNLOCKED);
  assign host_pop = reg_rd && (reg_addr == ADDR_QUEUE_HEAD) && (count_reg != COUNT_ZERO);
  assign lock_wr  = reg_wr && (reg_addr == ADDR_LOCK_COUNT);

  // Locked keys are not queued; inputs only when the mode bit allows
  always_comb
  begin
    if (!cap_gpi_reg)
      record = ev_new && !locked;
    else
      record = ev_new && sel_ok && !(locked && cfg_input_event_mode);
  end

  assign count_after_pop = 4'(count_reg - {3'h0, host_pop});
  assign full            = (count_after_pop == FIFO_FULL);
  assign ovf             = record && full;
  assign push            = record && (!full || cfg_overflow_keep_newest);
  assign drop_oldest     = ovf && cfg_overflow_keep_newest;
  assign push_idx        = 4'(count_after_pop - {3'h0, drop_oldest});
  assign count_next      = 4'(count_after_pop + {3'h0, push && !drop_oldest});

  // Event count register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      count_reg <= COUNT_ZERO;
    else
      count_reg <= count_next;
  end

  kefl_event_store u_store (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pop       (host_pop || drop_oldest),
    .push      (push),
    .push_idx  (push_idx),
    .push_data ({cap_press_reg, ev_code}),
    .head      (head)
  );

  // Flag sources; a set in the clearing cycle survives
  always_comb
  begin
    flags_set             = 8'h00;
    flags_set[FLAG_KEY]   = (push && !cap_gpi_reg) || mask_fire;
    flags_set[FLAG_INPUT] = push && cap_gpi_reg;
    flags_set[FLAG_LOCK]  = unlock_done;
    flags_set[FLAG_OVF]   = ovf;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags_reg <= 8'h00;
    else if (reg_wr && (reg_addr == ADDR_EVENT_FLAGS))
      flags_reg <= (flags_reg & ~reg_wdata) | flags_set;
    else
      flags_reg <= flags_reg | flags_set;
  end

  // Active-low interrupt; overflow only when its alert is enabled
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_n <= 1'b1;
    else
      irq_n <= !(flags_reg[FLAG_KEY] || flags_reg[FLAG_INPUT] || flags_reg[FLAG_LOCK] ||
                 (flags_reg[FLAG_OVF] && cfg_overflow_alert_enable));
  end

  // Register read port; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        unique case (reg_addr)
          ADDR_EVENT_FLAGS: reg_rdata <= flags_reg;
          ADDR_LOCK_COUNT:  reg_rdata <= {1'b0, locked, (lock_state_reg == LK_GOT_FIRST),
                                          (lock_state_reg == LK_GOT_FIRST), count_reg};
          ADDR_QUEUE_HEAD:  reg_rdata <= (count_reg == COUNT_ZERO) ? 8'h00 : head;
          default:          reg_rdata <= 8'h00;
        endcase
    end
  end

  // Lock timers: prescalers idle while their timer is stopped
  logic [PRESCALE_W-1:0] un_pre_reg, mask_pre_reg;
  logic [2:0]            un_sec_reg, un_limit;
  logic [4:0]            mask_sec_reg, mask_limit;
  logic                  mask_run_reg, un_run, un_exp, mask_exp;

  assign un_limit   = lock_timers[UNLOCK_MSB:UNLOCK_LSB];
  assign mask_limit = lock_timers[MASK_MSB:MASK_LSB];
  assign un_run     = (lock_state_reg == LK_GOT_FIRST) && (un_limit != 3'h0);
  assign un_exp     = un_run && sec_done(un_pre_reg) && (3'(un_sec_reg + 3'h1) == un_limit);
  assign mask_exp   = mask_run_reg && sec_done(mask_pre_reg) &&
                      (5'(mask_sec_reg + 5'h01) == mask_limit);
  assign lock_press = ev_new && cap_press_reg && sel_ok && locked;
  assign mask_fire  = lock_press && (mask_limit != 5'h00) && !mask_run_reg;

  // Unlock window counter, restarted by every first key
  always_ff @(posedge clk)
  begin
    if (sys_rst || !un_run || (lock_press && (ev_code == first_unlock_key)))
    begin
      un_pre_reg <= '0;
      un_sec_reg <= 3'h0;
    end
    else if (sec_done(un_pre_reg))
    begin
      un_pre_reg <= '0;
      un_sec_reg <= 3'(un_sec_reg + 3'h1);
    end
    else
      un_pre_reg <= PRESCALE_W'(un_pre_reg + 1'b1);
  end

  // Mask window: one interrupt per window while locked
  always_ff @(posedge clk)
  begin
    if (sys_rst || !locked || mask_exp)
    begin
      mask_run_reg <= 1'b0;
      mask_pre_reg <= '0;
      mask_sec_reg <= 5'h00;
    end
    else if (mask_fire)
      mask_run_reg <= 1'b1;
    else if (mask_run_reg && sec_done(mask_pre_reg))
    begin
      mask_pre_reg <= '0;
      mask_sec_reg <= 5'(mask_sec_reg + 5'h01);
    end
    else if (mask_run_reg)
      mask_pre_reg <= PRESCALE_W'(mask_pre_reg + 1'b1);
  end

  // Lock state machine; host writes take priority over key presses
  assign unlock_done = (lock_state_reg == LK_GOT_FIRST) && lock_press &&
                       (ev_code == second_unlock_key) && !lock_wr;

  always_comb
  begin
    lock_state_next = lock_state_reg;
    if (lock_wr && !reg_wdata[LOCK_REQ_BIT])
      lock_state_next = LK_UNLOCKED;
    else if (lock_wr && (lock_state_reg == LK_UNLOCKED))
      lock_state_next = LK_LOCKED;
    else
      unique case (lock_state_reg)
        LK_UNLOCKED: lock_state_next = LK_UNLOCKED;
        LK_LOCKED:
        begin
          if (lock_press && (ev_code == first_unlock_key))
            lock_state_next = LK_GOT_FIRST;
        end
        LK_GOT_FIRST:
        begin
          if (unlock_done)
            lock_state_next = LK_UNLOCKED;
          else if (un_exp || mask_exp)
            lock_state_next = LK_LOCKED;
          else if (lock_press && (ev_code != first_unlock_key))
            lock_state_next = LK_LOCKED;
        end
        default: lock_state_next = LK_LOCKED;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lock_state_reg <= LK_UNLOCKED;
    else
      lock_state_reg <= lock_state_next;
  end

  // Checks on the system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_count_max;
    count_reg <= FIFO_FULL;
  endproperty
  a_count_max: assert property (p_count_max) else $error("event count above ten");

  property p_empty_read;
    (reg_rd && reg_addr == ADDR_QUEUE_HEAD && count_reg == COUNT_ZERO && !ev_new)
      |=> (reg_rdata == 8'h00) && (count_reg == COUNT_ZERO);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty head read not zero");

  property p_pop_dec;
    (host_pop && !ev_new) |=> count_reg == 4'($past(count_reg) - COUNT_ONE);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("head read did not decrement");

  property p_head_data;
    host_pop |=> reg_rvalid && (reg_rdata == $past(head)) && (reg_rdata != 8'h00);
  endproperty
  a_head_data: assert property (p_head_data) else $error("head read wrong data");

  property p_ovf_flag;
    (record && count_reg == FIFO_FULL && !host_pop) |=> flags_reg[FLAG_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_ovf_irq;
    (flags_reg[FLAG_OVF] && cfg_overflow_alert_enable) |=> !irq_n;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow alert not driven");

  property p_drop_new;
    (ovf && !cfg_overflow_keep_newest && !host_pop) |=> (count_reg == FIFO_FULL) && $stable(head);
  endproperty
  a_drop_new: assert property (p_drop_new) else $error("drop policy changed queue");

  property p_lock_wr;
    (lock_wr && reg_wdata[LOCK_REQ_BIT] && !locked) |=> lock_state_reg == LK_LOCKED ##1 locked;
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("lock write did not lock");

  property p_unlock_wr;
    (lock_wr && !reg_wdata[LOCK_REQ_BIT]) |=> !locked;
  endproperty
  a_unlock_wr: assert property (p_unlock_wr) else $error("unlock write ignored");

  property p_w1c;
    (reg_wr && reg_addr == ADDR_EVENT_FLAGS && reg_wdata[FLAG_LOCK] && !unlock_done)
      |=> !flags_reg[FLAG_LOCK];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_locked_no_key;
    (locked && !lock_wr) |=> !$rose(flags_reg[FLAG_KEY]) || $past(mask_fire);
  endproperty
  a_locked_no_key: assert property (p_locked_no_key) else $error("key flag while locked");

  c_overflow:  cover property (ovf && cfg_overflow_keep_newest);
  c_drain:     cover property (host_pop && count_reg == COUNT_ONE);
  c_unlock:    cover property (unlock_done);
  c_mask_fire: cover property (mask_fire);

endmodule // kefl_event_fifo_lock

// file: logic/kefl_event_store.sv
// Ten-entry shifting event store; entry 0 is always the oldest event.
// Assumes the caller never pushes beyond the current count and pops only when not empty.
`timescale 1ns/10ps
module kefl_event_store
  import kefl_pkg::*;
(
  input  logic       clk,
  input  logic       sys_rst,
  input  logic       pop,
  input  logic       push,
  input  logic [3:0] push_idx,
  input  logic [7:0] push_data,
  output logic [7:0] head
);

  logic [7:0] mem_reg  [FIFO_DEPTH];
  logic [7:0] mem_next [FIFO_DEPTH];

  // Shift toward the head first, then write into the first free slot
  always_comb
  begin
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      // Index kept in range so the last slot never names a missing entry
      if (pop && (i == FIFO_DEPTH - 1))
        mem_next[i] = 8'h00;
      else if (pop)
        mem_next[i] = mem_reg[(i + 1) % FIFO_DEPTH];
      else
        mem_next[i] = mem_reg[i];
      if (push && (push_idx == 4'(i)))
        mem_next[i] = push_data;
    end
  end

  // Zero fill keeps an empty head reading zero
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < FIFO_DEPTH; i++)
      mem_reg[i] <= sys_rst ? 8'h00 : mem_next[i];
  end

  assign head = mem_reg[0];

endmodule // kefl_event_store

// file: logic/kefl_pkg.sv
// Package of the key event queue and keypad lock block.
// Assumes one system clock at 40 MHz; shared by the queue store and the top.
package kefl_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_LOCK_COUNT  = 8'h03;
  localparam logic [7:0] ADDR_QUEUE_HEAD  = 8'h04;

  // Queue geometry
  localparam int         FIFO_DEPTH = 10;
  localparam logic [3:0] FIFO_FULL  = 4'ha;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE  = 4'h1;

  // Event flag bit positions
  localparam int FLAG_KEY   = 0;
  localparam int FLAG_INPUT = 1;
  localparam int FLAG_LOCK  = 2;
  localparam int FLAG_OVF   = 3;

  // Lock and event count fields
  localparam int LOCK_REQ_BIT    = 6;
  localparam int LOCK_STATE_BIT  = 5;
  localparam int UNLOCK_PEND_BIT = 4;

  // Lock timer fields
  localparam int UNLOCK_LSB = 0;
  localparam int UNLOCK_MSB = 2;
  localparam int MASK_LSB   = 3;
  localparam int MASK_MSB   = 7;

  // Event byte layout and code bases
  localparam int         PRESS_BIT     = 7;
  localparam logic [6:0] MATRIX_COLS   = 7'h0a;
  localparam logic [6:0] MATRIX_BASE   = 7'h01;
  localparam logic [6:0] GPI_ROW_BASE  = 7'h61;
  localparam logic [6:0] GPI_COL_BASE  = 7'h69;
  localparam logic [4:0] GPI_COL_SEL   = 5'h08;
  localparam int         GPI_SEL_W     = 18;

  // Timebase: one second of system clock
  localparam int CLK_HZ             = 32'h0262_5a00;
  localparam int SECOND_S           = 1;
  localparam int SEC_CYCLES_DEFAULT = CLK_HZ * SECOND_S;
  localparam int PRESCALE_W         = 26;

  typedef enum logic [1:0] {LK_UNLOCKED, LK_LOCKED, LK_GOT_FIRST} kefl_lock_state_type;

endpackage

// file: tb/kefl_scan_model.sv
// Stand-in for the scan engine: offers one event at a time on the link clock.
// Assumes ev_clk runs free and that ev_busy answers every strobe that is taken.
`timescale 1ns/10ps
module kefl_scan_model
(
  input  logic       ev_clk,
  input  logic       ev_busy,
  output logic       ev_strobe,
  output logic [9:0] ev_bits,
  output logic       late
);
  // Quiet link at time zero; data lines carry a pattern, not a real event
  initial
  begin
    ev_strobe = 1'b0;
    ev_bits   = 10'h2aa;
    late      = 1'b0;
  end

  // Event bits are {gpi, on column, row, column, press}. The strobe is held to
  // the taking edge, then the data lines are inverted so a stale event is never
  // mistaken for a valid one. The wait sees busy rise, then fall, under a bound.
  task automatic send(input logic [9:0] e);
    int   n;
    logic seen;
    n    = 0;
    seen = 1'b0;
    @(posedge ev_clk) #2;
    ev_strobe = 1'b1;
    ev_bits   = e;
    @(posedge ev_clk) #2;
    ev_strobe = 1'b0;
    ev_bits   = ~e;
    while (n < 40 && !(seen && ev_busy === 1'b0))
    begin
      seen = seen | (ev_busy === 1'b1);
      @(posedge ev_clk) #2;
      n++;
    end
    late = late | (n == 40);
  endtask
endmodule // kefl_scan_model

// file: tb/tb.sv
// Bench for the key event queue and keypad lock block.
// Assumes the strobe register port and the link handshake of the design.
`timescale 1ns/10ps
module tb;
  import kefl_pkg::*;
  typedef struct packed {logic [9:0] ev; logic [7:0] exp;} kefl_row_type;
  localparam int SEC_SIM = 50;
  logic                 clk, ev_clk, sys_rst;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata, lock_timers;
  logic                 reg_wr, reg_rd, reg_rvalid, irq_n;
  logic                 alert_en, keep_new, in_mode;
  logic [GPI_SEL_W-1:0] in_sel;
  logic [6:0]           key_a, key_b;
  logic                 ev_strobe, ev_busy, src_late;
  logic [9:0]           ev_bits;
  int                   fails, check_count;
  // Matrix events {0, 0, row, column, press} beside the byte each reads back
  kefl_row_type rows [10] = '{'{10'h001, 8'h81}, '{10'h063, 8'ha0}, '{10'h000, 8'h01},
    '{10'h062, 8'h20}, '{10'h045, 8'h97}, '{10'h044, 8'h17}, '{10'h089, 8'had},
    '{10'h081, 8'ha9}, '{10'h080, 8'h29}, '{10'h088, 8'h2d}};

  // System clock 25 ns; link clock 30 ns, first edge at 1 ns so phases never line up
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    ev_clk = 1'b0;
    #1 ev_clk = 1'b1;
    forever #15 ev_clk = ~ev_clk;
  end

  kefl_event_fifo_lock #(.SEC_CYCLES(SEC_SIM)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cfg_overflow_alert_enable(alert_en), .cfg_overflow_keep_newest(keep_new),
    .cfg_input_event_mode(in_mode), .input_event_select(in_sel),
    .first_unlock_key(key_a), .second_unlock_key(key_b), .lock_timers(lock_timers),
    .irq_n(irq_n), .ev_clk(ev_clk), .ev_strobe(ev_strobe), .ev_is_gpi(ev_bits[9]),
    .ev_on_col(ev_bits[8]), .ev_row(ev_bits[7:5]), .ev_col(ev_bits[4:1]),
    .ev_press(ev_bits[0]), .ev_busy(ev_busy));

  kefl_scan_model src_u (.ev_clk(ev_clk), .ev_busy(ev_busy), .ev_strobe(ev_strobe),
    .ev_bits(ev_bits), .late(src_late));

  // Compare and count; four-state compare so an unknown never passes
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // All drivers move 2 ns after a clock edge, never twice in one time step
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk) #2 reg_wr = 1'b0;
  endtask

  // The answer must stand exactly one cycle after the read strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk) #2 reg_rd = 1'b0;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, exp);
  endtask

  // A lost handshake ends the run at once instead of hanging
  task automatic ev(input logic [9:0] e);
    src_u.send(e);
    if (src_late === 1'b1)
    begin
      fails++;
      complete_run();
    end
    tick(4);
  endtask

  task automatic fill();
    for (int i = 0; i < 10; i++)
      ev(rows[i].ev);
  endtask

  // With s = 1 the oldest event was pushed out and key 2 press sits at the tail
  task automatic drain(input int s);
    for (int i = 0; i < 10; i++)
    begin
      rd(ADDR_QUEUE_HEAD, (i + s < 10) ? rows[i + s].exp : 8'h82);
      rd(ADDR_LOCK_COUNT, 8'(9 - i));
    end
  endtask

  // Last resort against a hang anywhere in the sequence
  initial
  begin
    #400us;
    fails++;
    complete_run();
  end

  // Main sequence: queue, overflow in both policies, inputs, lock, mask timer
  initial
  begin
    fails       = 0;
    check_count = 0;
    sys_rst     = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    alert_en    = 1'b0;
    keep_new    = 1'b0;
    in_mode     = 1'b0;
    in_sel      = 18'h00408;
    key_a       = 7'h05;
    key_b       = 7'h64;
    lock_timers = 8'h03;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    rd(ADDR_EVENT_FLAGS, 8'h00);
    rd(ADDR_LOCK_COUNT, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    fill();
    rd(ADDR_LOCK_COUNT, 8'h0a);
    rd(ADDR_EVENT_FLAGS, 8'h01);
    ev(10'h003);
    rd(ADDR_EVENT_FLAGS, 8'h09);
    wr(ADDR_EVENT_FLAGS, 8'h01);
    tick(2);
    chk({7'h00, irq_n}, 8'h01);
    alert_en = 1'b1;
    tick(2);
    chk({7'h00, irq_n}, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'h08);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    drain(0);
    rd(ADDR_QUEUE_HEAD, 8'h00);
    rd(ADDR_LOCK_COUNT, 8'h00);
    keep_new = 1'b1;
    fill();
    ev(10'h003);
    drain(1);
    wr(ADDR_EVENT_FLAGS, 8'h0f);
    // Input events: row 3 and column 2 selected, row 4 not
    ev(10'h261);
    ev(10'h281);
    ev(10'h304);
    rd(ADDR_EVENT_FLAGS, 8'h02);
    rd(ADDR_LOCK_COUNT, 8'h02);
    rd(ADDR_QUEUE_HEAD, 8'he4);
    rd(ADDR_QUEUE_HEAD, 8'h6b);
    wr(ADDR_EVENT_FLAGS, 8'h0f);
    // Lock with no mask; second unlock key is an input event code
    in_mode = 1'b1;
    wr(ADDR_LOCK_COUNT, 8'h40);
    ev(10'h001);
    ev(10'h261);
    rd(ADDR_LOCK_COUNT, 8'h40);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    ev(10'h009);
    rd(ADDR_LOCK_COUNT, 8'h70);
    ev(10'h261);
    rd(ADDR_LOCK_COUNT, 8'h00);
    rd(ADDR_EVENT_FLAGS, 8'h04);
    ev(10'h001);
    rd(ADDR_QUEUE_HEAD, 8'h81);
    wr(ADDR_LOCK_COUNT, 8'h40);
    wr(ADDR_LOCK_COUNT, 8'h00);
    rd(ADDR_LOCK_COUNT, 8'h00);
    // Mask of one second, no unlock window limit
    wr(ADDR_EVENT_FLAGS, 8'h0f);
    lock_timers = 8'h08;
    wr(ADDR_LOCK_COUNT, 8'h40);
    ev(10'h009);
    rd(ADDR_EVENT_FLAGS, 8'h01);
    chk({7'h00, irq_n}, 8'h00);
    rd(ADDR_LOCK_COUNT, 8'h70);
    wr(ADDR_EVENT_FLAGS, 8'h01);
    ev(10'h009);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    tick(2 * SEC_SIM + 20);
    rd(ADDR_LOCK_COUNT, 8'h40);
    ev(10'h261);
    rd(ADDR_LOCK_COUNT, 8'h40);
    // Unlock window of one second, no mask: a wrong key and a timeout both fall back
    lock_timers = 8'h01;
    ev(10'h009);
    ev(10'h001);
    rd(ADDR_LOCK_COUNT, 8'h40);
    ev(10'h009);
    rd(ADDR_LOCK_COUNT, 8'h70);
    tick(SEC_SIM + 20);
    rd(ADDR_LOCK_COUNT, 8'h40);
    // Input events still queue during lock once the mode bit is clear
    in_mode = 1'b0;
    ev(10'h261);
    rd(ADDR_LOCK_COUNT, 8'h41);
    rd(ADDR_EVENT_FLAGS, 8'h03);
    // Reset in mid-run clears queue, flags and lock
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    rd(ADDR_LOCK_COUNT, 8'h00);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    rd(ADDR_QUEUE_HEAD, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    complete_run();
  end
endmodule // tb
